// >>> verilog/cam_capture_pkg.sv
// Constants shared by the parallel camera capture front end.
package cam_capture_pkg;
    // Data width select encodings.
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_10 = 2'h1;
    localparam logic [1:0] WIDTH_12 = 2'h2;
    localparam logic [1:0] WIDTH_14 = 2'h3;
    localparam logic [13:0] MASK_8 = 14'h00FF;
    localparam logic [13:0] MASK_10 = 14'h03FF;
    localparam logic [13:0] MASK_12 = 14'h0FFF;
    localparam logic [13:0] MASK_14 = 14'h3FFF;
    // Frame rate select encodings.
    localparam logic [1:0] RATE_ALL = 2'h0;
    localparam logic [1:0] RATE_HALF = 2'h1;
    localparam logic [1:0] RATE_QUARTER = 2'h2;
    // Embedded delimiter preamble and wildcard frame end code.
    localparam logic [23:0] CODE_PREAMBLE = 24'hFF0000;
    localparam logic [7:0] CODE_WILDCARD = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    // Unmask byte positions inside sync_code_unmask.
    localparam int FEU_POS = 24;
    localparam int LEU_POS = 16;
    localparam int LSU_POS = 8;
    localparam int FSU_POS = 0;
    // Configuration bundle carried into the pixel domain.
    localparam int CFG_W = 75;
    localparam int FIFO_AW = 2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum {
        ST_IDLE, ST_WAIT_FE, ST_WAIT_FS, ST_FRAME, ST_DONE
    } cap_state_t;
endpackage : cam_capture_pkg

// >>> verilog/cam_capture.sv
// Parallel camera capture front end with sync, packing and DMA handoff.
//****************************************************************
// Summary of operation
// - Data width 8 to 14, upper lines ignored.
// - Sample on the programmed pixel clock edge.
// - Active sync level marks blanking, data dropped.
// - Compressed streams: line sync frames each packet.
// - Unfinished compressed word is zero padded.
// - Delimiter is FF 00 00 plus code byte.
// - Active and blanking line codes mark lines.
// - Frame end code FF matches leftover codes.
// - Embedded capture starts after end then start.
// - Unmask bytes: end, line end, line start, start.
// - Compare only unmasked code bits.
// - No sampling until a frame start.
// - Snapshot clears capture enable after frame.
// - Snapshot overrun drops frame and disables.
// - Continuous: all, half or quarter frames.
// - Continuous stop takes effect at frame end.
// - Four word FIFO, DMA request per word.
// - Overrun or sync error flushes, waits start.
// - Byte one in bits 7..0, four in 31..24.
// - Flag embedded codes out of order.
//****************************************************************
`timescale 1ns/1ps
`default_nettype none
module cam_capture import cam_capture_pkg::*; (
    // System clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Camera pins
    input wire logic pixel_clk_line,
    input wire logic [13:0] cam_data,
    input wire logic cam_hsync,
    input wire logic cam_vsync,
    // Capture control
    input wire logic capture_start,
    input wire logic capture_stop,
    input wire logic snapshot_mode,
    input wire logic embedded_mode,
    input wire logic compressed_mode,
    input wire logic pclk_rising,
    input wire logic hsync_active_high,
    input wire logic vsync_active_high,
    input wire logic [1:0] width_sel,
    input wire logic [1:0] frame_rate_sel,
    input wire logic [31:0] sync_code_values,
    input wire logic [31:0] sync_code_unmask,
    input wire logic flag_clear,
    output logic capture_enable,
    output logic sync_order_error_flag,
    output logic overrun_flag,
    // DMA side
    output logic [31:0] capture_data_reg,
    output logic dma_req,
    input wire logic dma_ack
);
    //************************************************************
    // Pin sampling and configuration crossing
    //************************************************************
    logic [15:0] pos_reg, neg_reg, smp_reg;
    logic [CFG_W-1:0] cfg_s1, cfg_s2;
    logic c_rise, c_hpol, c_vpol, c_emb, c_jpg, c_snap, c_en;
    logic [1:0] c_w, c_rate;
    logic [31:0] c_code, c_umask;
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) pos_reg <= '0;
        else pos_reg <= {cam_hsync, cam_vsync, cam_data};
    end
    always_ff @(negedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) neg_reg <= '0;
        else neg_reg <= {cam_hsync, cam_vsync, cam_data};
    end
    // Quasi-static settings; software changes them only while idle.
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) begin
            cfg_s1 <= '0;
            cfg_s2 <= '0;
        end else begin
            cfg_s1 <= {pclk_rising, hsync_active_high, vsync_active_high,
                embedded_mode, compressed_mode, snapshot_mode,
                width_sel, frame_rate_sel, capture_enable,
                sync_code_values, sync_code_unmask};
            cfg_s2 <= cfg_s1;
        end
    end
    assign {c_rise, c_hpol, c_vpol, c_emb, c_jpg, c_snap, c_w, c_rate,
        c_en, c_code, c_umask} = cfg_s2;
    // Falling-edge samples are retimed here, a half period later.
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) smp_reg <= '0;
        else smp_reg <= c_rise ? pos_reg : neg_reg;
    end

    //************************************************************
    // Sync event detection
    //************************************************************
    logic [7:0] byte_in, b1, b2, b3;
    logic act_vs, act_hs, pv_reg, ph_reg, code_now;
    logic ev_fs, ev_fe, ev_ls, ev_le, m_fs, m_ls, m_le, m_fe;
    logic in_frm, in_line, pkt_end, err_ev;
    assign byte_in = smp_reg[7:0];
    assign act_vs = smp_reg[14] == c_vpol;
    assign act_hs = smp_reg[15] == c_hpol;
    assign code_now = {b3, b2, b1} == CODE_PREAMBLE;
    assign m_fs = ((byte_in ^ c_code[FSU_POS+:8])
        & c_umask[FSU_POS+:8]) == 8'h00;
    assign m_ls = ((byte_in ^ c_code[LSU_POS+:8])
        & c_umask[LSU_POS+:8]) == 8'h00;
    assign m_le = ((byte_in ^ c_code[LEU_POS+:8])
        & c_umask[LEU_POS+:8]) == 8'h00;
    assign m_fe = (c_code[FEU_POS+:8] == CODE_WILDCARD)
        ? !(m_fs || m_ls || m_le)
        : ((byte_in ^ c_code[FEU_POS+:8])
        & c_umask[FEU_POS+:8]) == 8'h00;
    assign ev_fs = c_emb ? code_now && m_fs : pv_reg && !act_vs;
    assign ev_fe = c_emb ? code_now && m_fe : !pv_reg && act_vs;
    assign ev_ls = c_emb && code_now && m_ls && !m_fs;
    assign ev_le = c_emb && code_now && m_le && !m_fs && !m_ls;
    assign pkt_end = c_jpg && !ph_reg && act_hs;
    assign err_ev = c_emb && ((ev_fs && in_frm)
        || (ev_ls && (in_line || !in_frm))
        || (ev_le && !in_line));
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) begin
            {b3, b2, b1} <= '0;
            pv_reg <= 1'b0;
            ph_reg <= 1'b0;
            in_frm <= 1'b0;
            in_line <= 1'b0;
        end else begin
            {b3, b2, b1} <= {b2, b1, byte_in};
            pv_reg <= act_vs;
            ph_reg <= act_hs;
            if (ev_fs) in_frm <= 1'b1;
            else if (ev_fe) in_frm <= 1'b0;
            if (ev_ls) in_line <= 1'b1;
            else if (ev_le || ev_fe) in_line <= 1'b0;
        end
    end

    //************************************************************
    // Frame sequencer
    //************************************************************
    cap_state_t st_reg;
    logic [1:0] dec_reg;
    logic take, smp_ok, push, full_w, ovr, flush;
    logic done_t, ovr_t, err_t;
    assign take = c_snap || c_rate == RATE_ALL
        || (c_rate == RATE_HALF && !dec_reg[0])
        || (c_rate == RATE_QUARTER && dec_reg == 2'h0);
    assign ovr = push && full_w;
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_IDLE;
            dec_reg <= 2'h0;
            done_t <= 1'b0;
            ovr_t <= 1'b0;
            err_t <= 1'b0;
        end else begin
            if (ovr) ovr_t <= !ovr_t;
            if (err_ev) err_t <= !err_t;
            case (st_reg)
                ST_IDLE: begin
                    dec_reg <= 2'h0;
                    if (c_en) st_reg <= c_emb ? ST_WAIT_FE : ST_WAIT_FS;
                end
                ST_WAIT_FE: begin
                    if (!c_en) st_reg <= ST_IDLE;
                    else if (ev_fe) st_reg <= ST_WAIT_FS;
                end
                ST_WAIT_FS: begin
                    if (!c_en) st_reg <= ST_IDLE;
                    else if (ev_fs) begin
                        dec_reg <= dec_reg + 2'h1;
                        if (take) st_reg <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (ovr || err_ev) begin
                        if (c_snap) begin
                            st_reg <= ST_DONE;
                            done_t <= !done_t;
                        end else st_reg <= ST_WAIT_FS;
                    end else if (ev_fe) begin
                        if (c_snap) begin
                            st_reg <= ST_DONE;
                            done_t <= !done_t;
                        end else if (!c_en) st_reg <= ST_IDLE;
                        else st_reg <= ST_WAIT_FS;
                    end
                end
                ST_DONE: if (!c_en) st_reg <= ST_IDLE;
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    //************************************************************
    // Data extraction and packing
    //************************************************************
    logic [31:0] pk_reg, nw;
    logic [1:0] pk_cnt;
    logic [13:0] dmask, dval;
    logic wfull;
    always_comb begin
        case (c_w)
            WIDTH_8: dmask = MASK_8;
            WIDTH_10: dmask = MASK_10;
            WIDTH_12: dmask = MASK_12;
            default: dmask = MASK_14;
        endcase
    end
    assign dval = smp_reg[13:0] & dmask;
    assign smp_ok = st_reg == ST_FRAME && (c_emb
        ? in_line && !code_now && byte_in != BYTE_ZERO
          && byte_in != BYTE_ONES
        : !act_vs && !act_hs);
    always_comb begin
        nw = pk_reg;
        if (c_w == WIDTH_8) nw[pk_cnt*8+:8] = dval[7:0];
        else nw[pk_cnt[0]*16+:16] = {2'b00, dval};
    end
    assign wfull = smp_ok && (c_w == WIDTH_8 ? pk_cnt == 2'h3
        : pk_cnt[0]);
    // Partial words are flushed zero filled at frame or packet end.
    assign flush = st_reg == ST_FRAME && (ev_fe || pkt_end)
        && pk_cnt != 2'h0;
    assign push = wfull || flush;
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) begin
            pk_reg <= RESET_WORD;
            pk_cnt <= 2'h0;
        end else if (push || st_reg != ST_FRAME) begin
            pk_reg <= RESET_WORD;
            pk_cnt <= 2'h0;
        end else if (smp_ok) begin
            pk_reg <= nw;
            pk_cnt <= pk_cnt + 2'h1;
        end
    end

    //************************************************************
    // Four word crossing FIFO
    //************************************************************
    logic [31:0] mem [0:3];
    logic [FIFO_AW:0] wb, wg, rb, rg, rg_s1, rg_s2, wg_s1, wg_s2;
    function automatic logic [FIFO_AW:0] g2b(input logic [FIFO_AW:0] g);
        g2b = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
    endfunction : g2b
    assign full_w = wg == {~rg_s2[2:1], rg_s2[0]};
    // A word pushed into a full FIFO is lost; only the flag reports it.
    always_ff @(posedge pixel_clk_line or negedge arst_n) begin
        if (!arst_n) begin
            wb <= '0;
            wg <= '0;
            rg_s1 <= '0;
            rg_s2 <= '0;
        end else begin
            rg_s1 <= rg;
            rg_s2 <= rg_s1;
            if (push && !full_w) begin
                wb <= wb + 3'h1;
                wg <= (wb + 3'h1) ^ ((wb + 3'h1) >> 1);
            end
        end
    end
    always_ff @(posedge pixel_clk_line) begin
        if (push && !full_w) mem[wb[1:0]] <= wfull ? nw : pk_reg;
    end

    //************************************************************
    // System domain: events, control and DMA word
    //************************************************************
    logic [2:0] dn_s, ov_s, er_s;
    logic done_ev, ovr_ev, err_sev, empty;
    // Toggle crossing assumes the bus clock outruns the pixel clock.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dn_s <= '0;
            ov_s <= '0;
            er_s <= '0;
            wg_s1 <= '0;
            wg_s2 <= '0;
        end else begin
            dn_s <= {dn_s[1:0], done_t};
            ov_s <= {ov_s[1:0], ovr_t};
            er_s <= {er_s[1:0], err_t};
            wg_s1 <= wg;
            wg_s2 <= wg_s1;
        end
    end
    assign done_ev = dn_s[2] ^ dn_s[1];
    assign ovr_ev = ov_s[2] ^ ov_s[1];
    assign err_sev = er_s[2] ^ er_s[1];
    assign empty = rg == wg_s2;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) capture_enable <= 1'b0;
        else if (capture_start) capture_enable <= 1'b1;
        else if (capture_stop || done_ev) capture_enable <= 1'b0;
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync_order_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            if (err_sev) sync_order_error_flag <= 1'b1;
            else if (flag_clear) sync_order_error_flag <= 1'b0;
            if (ovr_ev) overrun_flag <= 1'b1;
            else if (flag_clear) overrun_flag <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rb <= '0;
            rg <= '0;
            capture_data_reg <= RESET_WORD;
            dma_req <= 1'b0;
        end else if (ovr_ev || err_sev) begin
            rb <= g2b(wg_s2);
            rg <= wg_s2;
        end else begin
            if (dma_ack) dma_req <= 1'b0;
            if (!empty && (!dma_req || dma_ack)) begin
                capture_data_reg <= mem[rb[1:0]];
                dma_req <= 1'b1;
                rb <= rb + 3'h1;
                rg <= (rb + 3'h1) ^ ((rb + 3'h1) >> 1);
            end
        end
    end

    //************************************************************
    // Assertions
    //************************************************************
    sequence s_arm;
        st_reg == ST_WAIT_FE && c_en && !ev_fe;
    endsequence
    a_dma_req_hold: assert property (@(posedge clock) disable iff (!arst_n)
        dma_req && !dma_ack && !ovr_ev && !err_sev |=> dma_req)
        else $error("dma request dropped without acknowledge");
    a_err_sticky: assert property (@(posedge clock) disable iff (!arst_n)
        sync_order_error_flag && !flag_clear |=> sync_order_error_flag)
        else $error("sync error flag cleared by itself");
    a_snap_clear: assert property (@(posedge clock) disable iff (!arst_n)
        done_ev && !capture_start |=> !capture_enable)
        else $error("capture enable kept after snapshot");
    a_ovr_flag: assert property (@(posedge clock) disable iff (!arst_n)
        ovr_ev |=> overrun_flag && empty)
        else $error("overrun did not flag and flush");
    a_blank_drop: assert property (@(posedge pixel_clk_line)
        disable iff (!arst_n) !c_emb && (act_vs || act_hs) |-> !smp_ok)
        else $error("blanking sample accepted");
    a_wait_start: assert property (@(posedge pixel_clk_line)
        disable iff (!arst_n) st_reg != ST_FRAME |-> !push)
        else $error("word pushed outside a frame");
    a_emb_arm: assert property (@(posedge pixel_clk_line)
        disable iff (!arst_n) s_arm |=> st_reg == ST_WAIT_FE)
        else $error("frame taken before frame end seen");
    a_pack_low: assert property (@(posedge pixel_clk_line)
        disable iff (!arst_n) c_w == WIDTH_8 && smp_ok && pk_cnt == 2'h0
        && !push |=> pk_reg[7:0] == $past(byte_in))
        else $error("first byte not in low lane");
    a_snap_ovr: assert property (@(posedge pixel_clk_line)
        disable iff (!arst_n) st_reg == ST_FRAME && c_snap && ovr
        |=> st_reg == ST_DONE)
        else $error("snapshot overrun did not disable");
endmodule : cam_capture
`default_nettype wire

// >>> bench/cam_sensor_model.sv
// Behavioural parallel camera that drives the capture port pins.
`timescale 1ns/1ps
`default_nettype none
module cam_sensor_model #(
    // Half pixel period; 66 ns keeps the bus clock 2.64 times faster.
    parameter int HALF_NS = 33
) (
    // Camera pins
    output logic pixel_clk_line,
    output logic [13:0] cam_data,
    output logic cam_hsync,
    output logic cam_vsync,
    // Port configuration seen by the camera
    input wire logic pclk_rising,
    input wire logic hsync_active_high,
    input wire logic vsync_active_high
);
    //****************
    // Pixel timing
    //****************
    logic [13:0] last = 14'h1555;

    // The clock idles at the non-sampling level, so it stands still
    // between calls and gives no stray sampling edge.
    task automatic tick(input logic [13:0] d, input logic hs, input logic vs);
        last = d;
        cam_data = d;
        cam_hsync = hs ~^ hsync_active_high;
        cam_vsync = vs ~^ vsync_active_high;
        pixel_clk_line = ~pclk_rising;
        #(HALF_NS) pixel_clk_line = pclk_rising;
        #(HALF_NS) pixel_clk_line = ~pclk_rising;
    endtask : tick

    // Vertical blanking; data toggles so stale values never look valid.
    task automatic blank(input int n);
        repeat (n) tick(~last, 1'b0, 1'b1);
    endtask : blank

    //****************
    // Frames and codes
    //****************
    // An open frame ends on line sync only, as a compressed packet does.
    task automatic hw_frame(input int lines, input int npix,
                            input logic [13:0] base, input logic close);
        blank(4);
        for (int l = 0; l < lines; l++) begin
            tick(~last, 1'b1, 1'b0);
            tick(~last, 1'b1, 1'b0);
            for (int p = 0; p < npix; p++) begin
                tick(base + 14'(l * npix + p), 1'b0, 1'b0);
            end
        end
        repeat (4) tick(~last, !close, close);
    endtask : hw_frame

    task automatic code(input logic [7:0] xy);
        tick(14'h00FF, 1'b0, 1'b0);
        tick(14'h0000, 1'b0, 1'b0);
        tick(14'h0000, 1'b0, 1'b0);
        tick({6'h00, xy}, 1'b0, 1'b0);
    endtask : code
endmodule : cam_sensor_model
`default_nettype wire

// >>> bench/parallel_camera_capture_sync_tb.sv
// Self-checking testbench of the parallel camera capture front end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value %s: expected %0h, seen %0h", nm, (exp), (got)); \
    end end
module parallel_camera_capture_sync_tb import cam_capture_pkg::*; ;
    //****************
    // Signals
    //****************
    logic clock, arst_n, capture_start, capture_stop, flag_clear, dma_ack;
    logic snapshot_mode, embedded_mode, compressed_mode, pclk_rising;
    logic hsync_active_high, vsync_active_high;
    logic [1:0] width_sel, frame_rate_sel;
    logic [31:0] sync_code_values, sync_code_unmask, capture_data_reg;
    logic pixel_clk_line, cam_hsync, cam_vsync;
    logic [13:0] cam_data;
    logic capture_enable, sync_order_error_flag, overrun_flag, dma_req;
    int miscompares, num_checks;

    cam_capture dut (
        .clock, .arst_n, .pixel_clk_line, .cam_data, .cam_hsync, .cam_vsync,
        .capture_start, .capture_stop, .snapshot_mode, .embedded_mode,
        .compressed_mode, .pclk_rising, .hsync_active_high,
        .vsync_active_high, .width_sel, .frame_rate_sel, .sync_code_values,
        .sync_code_unmask, .flag_clear, .capture_enable,
        .sync_order_error_flag, .overrun_flag, .capture_data_reg, .dma_req,
        .dma_ack
    );
    cam_sensor_model cam (
        .pixel_clk_line, .cam_data, .cam_hsync, .cam_vsync, .pclk_rising,
        .hsync_active_high, .vsync_active_high
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    //****************
    // Access tasks
    //****************
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic strobe(input logic st, input logic sp, input logic fc);
        @(posedge clock);
        capture_start <= st;
        capture_stop <= sp;
        flag_clear <= fc;
        @(posedge clock);
        capture_start <= 1'b0;
        capture_stop <= 1'b0;
        flag_clear <= 1'b0;
        #1;
    endtask : strobe

    // Settings change only while capture is off, then the link idles.
    task automatic cfg(input logic sn, input logic em, input logic cm,
                       input logic ri, input logic hh, input logic vh,
                       input logic [1:0] w, input logic [1:0] r);
        @(posedge clock);
        snapshot_mode <= sn;
        embedded_mode <= em;
        compressed_mode <= cm;
        pclk_rising <= ri;
        hsync_active_high <= hh;
        vsync_active_high <= vh;
        width_sel <= w;
        frame_rate_sel <= r;
        cam.blank(4);
    endtask : cfg

    task automatic rd(input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (dma_req !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK("dma word", {dma_req, capture_data_reg}, {1'b1, exp})
        @(posedge clock);
        dma_ack <= 1'b1;
        @(posedge clock);
        dma_ack <= 1'b0;
    endtask : rd

    task automatic idle_check(input logic [2:0] exp);
        repeat (20) @(posedge clock);
        #1;
        `CHK("enable err req",
            {capture_enable, sync_order_error_flag, dma_req}, exp)
    endtask : idle_check

    //****************
    // Tests
    //****************
    initial begin
        int w;
        logic [13:0] m;
        capture_start = 1'b0;
        capture_stop = 1'b0;
        flag_clear = 1'b0;
        dma_ack = 1'b0;
        snapshot_mode = 1'b0;
        embedded_mode = 1'b0;
        compressed_mode = 1'b0;
        pclk_rising = 1'b1;
        hsync_active_high = 1'b1;
        vsync_active_high = 1'b1;
        width_sel = WIDTH_8;
        frame_rate_sel = RATE_ALL;
        sync_code_values = 32'hFFC780B5;
        sync_code_unmask = 32'hFFEFCF10;
        miscompares = 0;
        num_checks = 0;
        arst_n = 1'b0;
        cam.blank(3);
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("reset outputs",
            {capture_enable, sync_order_error_flag, overrun_flag, dma_req,
            capture_data_reg}, 36'h0)
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, WIDTH_8, RATE_ALL);
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("capture enable", capture_enable, 1'b1)
        cam.hw_frame(2, 4, 14'h3A10, 1'b1);
        rd(32'h13121110);
        rd(32'h17161514);
        cam.hw_frame(1, 4, 14'h0020, 1'b1);
        idle_check(3'b000);
        $display("test snapshot done");
        for (w = 1; w < 4; w++) begin
            cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'(w), RATE_ALL);
            strobe(1'b1, 1'b0, 1'b0);
            cam.hw_frame(1, 2, 14'h2ABC, 1'b1);
            m = (w == 1) ? MASK_10 : (w == 2) ? MASK_12 : MASK_14;
            rd({2'b00, 14'h2ABD & m, 2'b00, 14'h2ABC & m});
            strobe(1'b0, 1'b1, 1'b0);
        end
        $display("test widths done");
        cfg(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, WIDTH_8, RATE_QUARTER);
        strobe(1'b1, 1'b0, 1'b0);
        for (w = 0; w < 4; w++) begin
            cam.hw_frame(1, 4, 14'(8'h40 + 8 * w), 1'b1);
        end
        fork
            cam.hw_frame(1, 4, 14'h0060, 1'b1);
            begin
                repeat (19) @(posedge clock);
                strobe(1'b0, 1'b1, 1'b0);
            end
        join
        rd(32'h43424140);
        rd(32'h63626160);
        cam.hw_frame(1, 4, 14'h0070, 1'b1);
        idle_check(3'b000);
        $display("test decimation done");
        cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, WIDTH_8, RATE_ALL);
        strobe(1'b1, 1'b0, 1'b0);
        cam.hw_frame(1, 6, 14'h0050, 1'b0);
        rd(32'h53525150);
        rd(32'h00005554);
        strobe(1'b0, 1'b1, 1'b0);
        // A stop only lands at stream end, so frame sync must close it.
        cam.blank(4);
        idle_check(3'b000);
        $display("test compressed done");
        cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, WIDTH_8, RATE_ALL);
        strobe(1'b1, 1'b0, 1'b0);
        cam.code(8'h31);
        cam.code(8'h42);
        cam.code(8'h3C);
        cam.code(8'h80);
        for (w = 1; w < 5; w++) begin
            cam.tick(14'(8'h60 + w), 1'b0, 1'b0);
        end
        cam.code(8'hC7);
        cam.code(8'h42);
        cam.blank(4);
        rd(32'h64636261);
        @(posedge clock);
        sync_code_values <= 32'h42C780B5;
        sync_code_unmask <= 32'h0FEFCF10;
        idle_check(3'b000);
        cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, WIDTH_8, RATE_ALL);
        strobe(1'b1, 1'b0, 1'b0);
        cam.code(8'h42);
        cam.code(8'h3C);
        cam.code(8'hC7);
        cam.blank(4);
        idle_check(3'b110);
        strobe(1'b0, 1'b1, 1'b1);
        `CHK("order flag", sync_order_error_flag, 1'b0)
        $display("test embedded done");
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, WIDTH_8, RATE_ALL);
        strobe(1'b1, 1'b0, 1'b0);
        cam.hw_frame(1, 24, 14'h0001, 1'b1);
        repeat (10) @(posedge clock);
        #1;
        `CHK("overrun enable", {overrun_flag, capture_enable}, 2'b10)
        rd(32'h04030201);
        idle_check(3'b000);
        strobe(1'b0, 1'b0, 1'b1);
        `CHK("overrun flag", overrun_flag, 1'b0)
        $display("test overrun done");
        stop_test();
    end

    // The whole run needs well under 100 us; a hang is cut off here.
    initial begin
        #400us;
        miscompares++;
        $display("wrong value run time: expected finish, seen timeout");
        stop_test();
    end
endmodule : parallel_camera_capture_sync_tb
`default_nettype wire
